// [hw/ccs_pkg.sv]
// Constants, types and helpers of the charge-current setting port.
// Assumes a single write-only serial master on the link.
package ccs_pkg;

	localparam logic [7:0]  CCS_WR_ADDR     = 8'h12;
	localparam logic [7:0]  CCS_CMD_SMBUS   = 8'h14;
	localparam logic [7:0]  CCS_CMD_VOLTAGE = 8'h15;
	localparam logic [7:0]  CCS_REG_LOW     = 8'h02;
	localparam logic [7:0]  CCS_REG_HIGH    = 8'h03;
	localparam logic [7:0]  CCS_CRC_POLY    = 8'h07;
	localparam logic [7:0]  CCS_CRC_INIT    = 8'h00;
	localparam logic [15:0] CCS_RESET_VAL   = 16'h0000;
	localparam logic [15:0] CCS_IMPL_MASK   = 16'h1FC0;
	localparam logic [2:0]  CCS_HI_RESV_MSB = 3'h7;
	localparam logic [2:0]  CCS_HI_RESV_LSB = 3'h5;
	localparam int          CCS_CUR_LSB     = 6;
	localparam int          CCS_CUR_MSB     = 12;
	localparam logic [3:0]  CCS_BIT_ACK     = 4'h8;
	localparam logic [2:0]  CCS_BYTE_PEC    = 3'h4;

	// Data bytes, high byte first; the low byte leads on the wire
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} ccs_word_t;

	function automatic logic [7:0] ccs_crc_step(input logic [7:0] crc, input logic din);
		logic fb;
		fb = crc[7] ^ din;
		return {crc[6:0], 1'b0} ^ (fb ? CCS_CRC_POLY : 8'h00);
	endfunction

endpackage

// [hw/ccs_charge_current_port.sv]
// Charge-current setting register written by a gauge over the serial link.
// Link logic runs on the link clock; the register lives on core_clk.
// Assumes SCL stands still outside frames and the master never reads.
`timescale 1ns/1ps
module ccs_charge_current_port
	import ccs_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        scl_clk,
	input  wire logic        sda_i,
	output wire logic        sda_o,
	output wire logic        sda_oe,
	output logic      [15:0] charge_current_setting,
	output logic      [13:0] charge_current_ma,
	output logic             setting_updated
);

	////////////////////////////////////////////////////////////////
	// Start detection: data falls while the link clock is high
	logic start_tgl_q;
	always_ff @(negedge sda_i or posedge rst) begin
		if (rst) begin
			start_tgl_q <= 1'b0;
		end else if (scl_clk) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Link domain receiver
	logic        seen_tgl_q;
	logic        active_q;
	logic [3:0]  bit_cnt_q;
	logic [2:0]  byte_cnt_q;
	logic [6:0]  shift_q;
	logic [7:0]  crc_q;
	logic [7:0]  cmd_q;
	ccs_word_t   rx_q;
	ccs_word_t   word_q;
	logic        commit_tgl_q;
	logic        ack_q;

	wire         start_seen   = start_tgl_q != seen_tgl_q;
	wire  [7:0]  byte_in      = {shift_q, sda_i};
	wire         byte_done    = active_q && !start_seen && bit_cnt_q == 4'h7;
	wire         ack_clock    = active_q && !start_seen && bit_cnt_q == CCS_BIT_ACK;
	wire         cmd_ok       = cmd_q == CCS_CMD_SMBUS || cmd_q == CCS_REG_LOW;
	wire         crc_ok       = crc_q == CCS_CRC_INIT;
	wire         resv_ok      = rx_q.hi[CCS_HI_RESV_MSB:CCS_HI_RESV_LSB] == 3'h0;
	wire         commit_ok    = ack_clock && byte_cnt_q == CCS_BYTE_PEC && cmd_ok && crc_ok && resv_ok;

	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			seen_tgl_q <= 1'b0;
			active_q   <= 1'b0;
			bit_cnt_q  <= 4'h0;
			byte_cnt_q <= 3'h0;
			shift_q    <= 7'h00;
			crc_q      <= CCS_CRC_INIT;
		end else if (start_seen) begin
			// Repeated or fresh start abandons any partial frame
			seen_tgl_q <= start_tgl_q;
			active_q   <= 1'b1;
			bit_cnt_q  <= 4'h1;
			byte_cnt_q <= 3'h0;
			shift_q    <= {6'h00, sda_i};
			crc_q      <= ccs_crc_step(CCS_CRC_INIT, sda_i);
		end else if (ack_clock) begin
			bit_cnt_q  <= 4'h0;
			byte_cnt_q <= byte_cnt_q + 3'h1;
			active_q   <= byte_cnt_q != CCS_BYTE_PEC;
		end else if (active_q) begin
			// PEC bits run through the CRC too, so a match leaves zero
			bit_cnt_q  <= bit_cnt_q + 4'h1;
			shift_q    <= byte_in[6:0];
			crc_q      <= ccs_crc_step(crc_q, sda_i);
			if (byte_done && byte_cnt_q == 3'h0 && byte_in != CCS_WR_ADDR) begin
				active_q <= 1'b0;
			end
		end
	end

	// Byte capture; every addressed frame overwrites the bytes, good or not
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			cmd_q <= 8'h00;
			rx_q  <= '0;
		end else if (byte_done) begin
			case (byte_cnt_q)
				3'h1:    cmd_q    <= byte_in;
				3'h2:    rx_q.lo  <= byte_in;
				3'h3:    rx_q.hi  <= byte_in;
				default: cmd_q    <= cmd_q;
			endcase
		end
	end

	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			word_q       <= '0;
			commit_tgl_q <= 1'b0;
		end else if (commit_ok) begin
			word_q       <= rx_q;
			commit_tgl_q <= ~commit_tgl_q;
		end
	end

	// Acknowledge driven from the falling edge so it is stable for the high phase
	always_ff @(negedge scl_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= active_q && bit_cnt_q == CCS_BIT_ACK;
		end
	end

	assign sda_oe = ack_q;
	assign sda_o  = 1'b0;

	////////////////////////////////////////////////////////////////
	// Core domain: toggle crossing, word is stable once toggle is seen
	logic        sync1_q;
	logic        sync2_q;
	logic        sync3_q;
	logic [15:0] setting_q;
	logic [13:0] ma_q;
	logic        upd_q;

	wire         commit_evt = sync2_q != sync3_q;
	wire  [15:0] setting_d  = word_q & CCS_IMPL_MASK;
	wire  [13:0] ma_d       = {setting_d[CCS_CUR_MSB:CCS_CUR_LSB], 7'h00};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= commit_tgl_q;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			setting_q <= CCS_RESET_VAL;
			ma_q      <= 14'h0000;
			upd_q     <= 1'b0;
		end else begin
			upd_q <= commit_evt;
			if (commit_evt) begin
				setting_q <= setting_d;
				ma_q      <= ma_d;
			end
		end
	end

	assign charge_current_setting = setting_q;
	assign charge_current_ma      = ma_q;
	assign setting_updated        = upd_q;

	////////////////////////////////////////////////////////////////
	// Checks
	AST_HI_RESV_ZERO: assert property (@(posedge core_clk) disable iff (rst)
		setting_q[15:13] == 3'h0) else $error("Reserved high bits set");

	AST_LO_RESV_ZERO: assert property (@(posedge core_clk) disable iff (rst)
		setting_q[5:0] == 6'h00) else $error("Ignored low bits stored");

	AST_MA_WEIGHT: assert property (@(posedge core_clk) disable iff (rst)
		ma_q == {setting_q[12:6], 7'h00}) else $error("Current sum wrong");

	AST_LOW_WEIGHTS: assert property (@(posedge core_clk) disable iff (rst)
		ma_q[8:7] == setting_q[7:6]) else $error("Low byte weights wrong");

	AST_UPDATE_WORD: assert property (@(posedge core_clk) disable iff (rst)
		commit_evt |=> setting_q == (word_q & 16'h1FC0) && upd_q) else $error("Update lost");

	AST_HOLD_OTHERWISE: assert property (@(posedge core_clk) disable iff (rst)
		!commit_evt |=> $stable(setting_q) && !upd_q) else $error("Register moved");

	AST_BAD_CRC: assert property (@(posedge scl_clk) disable iff (rst)
		ack_clock && byte_cnt_q == 3'h4 && crc_q != 8'h00 |=> $stable(commit_tgl_q))
		else $error("Bad CRC committed");

	AST_CMD_FILTER: assert property (@(posedge scl_clk) disable iff (rst)
		ack_clock && cmd_q != 8'h14 && cmd_q != 8'h02 |=> $stable(commit_tgl_q))
		else $error("Foreign command committed");

	AST_INVALID_WRITE: assert property (@(posedge scl_clk) disable iff (rst)
		ack_clock && rx_q.hi[7:5] != 3'h0 |=> $stable(commit_tgl_q))
		else $error("Invalid write committed");

	AST_ADDR_NACK: assert property (@(posedge scl_clk) disable iff (rst)
		byte_done && byte_cnt_q == 3'h0 && byte_in != 8'h12 |=> !active_q ##1 !ack_q)
		else $error("Foreign address acked");

endmodule

// [tb/ccs_gauge_model.sv]
// Gauge model: sends write-word packets as the link master.
// Assumes a pull-up on the data line; the link clock idles high between frames.
`timescale 1ns/1ps
module ccs_gauge_model (
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic put(input logic [7:0] v, inout int acks);
		for (int i = 7; i >= 0; i--) begin
			#32 scl = 1'b0;
			#16 sda_pull = ~v[i];
			#16 scl = 1'b1;
		end
		#32 scl = 1'b0;
		#16 sda_pull = 1'b0;
		#16 scl = 1'b1;
		acks += int'(sda === 1'b0);
	endtask

	task automatic frame(input logic [7:0] a, c, lo, hi, input logic bad, output int acks);
		logic [7:0]  crc;
		logic [31:0] pkt;
		pkt = {a, c, lo, hi};
		crc = 8'h00;
		for (int i = 31; i >= 0; i--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ pkt[i]) ? 8'h07 : 8'h00);
		acks = 0;
		#16 sda_pull = 1'b1;
		for (int i = 3; i >= 0; i--)
			put(pkt[i*8 +: 8], acks);
		put(crc ^ {7'h00, bad}, acks);
		#32 scl = 1'b0;
		#16 sda_pull = 1'b1;
		#16 scl = 1'b1;
		#16 sda_pull = 1'b0;
	endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the charge-current setting port.
// Assumes the gauge model drives the link; the core clock is unrelated to it.
`timescale 1ns/1ps
module testbench;
	import ccs_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b0;
	logic        scl;
	logic        sda_pull;
	logic        sda_o;
	logic        sda_oe;
	logic [15:0] setting;
	logic [13:0] ma;
	logic        upd;
	int          n_errors = 0;
	int          total_checks = 0;
	int          n_upd = 0;
	wire         sda_line = !(sda_pull || (sda_oe && !sda_o));

	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (upd === 1'b1) n_upd++;

	ccs_gauge_model ccs_gauge_model_i (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));
	ccs_charge_current_port ccs_charge_current_port_i (.core_clk(core_clk), .rst(rst), .scl_clk(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .charge_current_setting(setting),
		.charge_current_ma(ma), .setting_updated(upd));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic run(input logic [7:0] a, c, lo, hi, input logic bad, input logic [15:0] e, input int ea, eu);
		int na;
		int u0;
		u0 = n_upd;
		ccs_gauge_model_i.frame(a, c, lo, hi, bad, na);
		repeat (8) @(posedge core_clk);
		chk(na == ea, "ack count");
		chk(setting === e, "setting");
		chk(ma === {e[12:6], 7'h00}, "current");
		chk(n_upd - u0 == eu, "update pulse");
	endtask

	task automatic t_reset;
		chk(setting === 16'h0000 && ma === 14'h0000, "reset value");
		$display("test reset done");
	endtask

	task automatic t_example;
		run(8'h12, 8'h14, 8'hC4, 8'h09, 1'b0, 16'h09C0, 5, 1);
		chk(ma === 14'h1380, "example current");
		// Periodic rebroadcast of the same word still lands and pulses
		run(8'h12, 8'h14, 8'hC4, 8'h09, 1'b0, 16'h09C0, 5, 1);
		$display("test example done");
	endtask

	task automatic t_weights;
		run(8'h12, 8'h02, 8'hFF, 8'h1F, 1'b0, 16'h1FC0, 5, 1);
		chk(ma === 14'h3F80, "full scale current");
		run(8'h12, 8'h14, 8'h40, 8'h10, 1'b0, 16'h1040, 5, 1);
		run(8'h12, 8'h14, 8'h80, 8'h01, 1'b0, 16'h0180, 5, 1);
		$display("test weights done");
	endtask

	task automatic t_refused;
		for (int i = 5; i < 8; i++)
			run(8'h12, 8'h14, 8'h40, 8'h01 << i, 1'b0, 16'h0180, 5, 0);
		run(8'h12, 8'h14, 8'h40, 8'h00, 1'b1, 16'h0180, 5, 0);
		run(8'h12, 8'h15, 8'hD0, 8'h20, 1'b0, 16'h0180, 5, 0);
		run(8'h20, 8'h14, 8'h40, 8'h00, 1'b0, 16'h0180, 0, 0);
		$display("test refused done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		// Raised after time zero so the link-side flops see a reset edge
		#1 rst = 1'b1;
		repeat (16) @(posedge core_clk);
		#1 rst = 1'b0;
		#117;
		t_reset();
		t_example();
		t_weights();
		t_refused();
		report_and_stop();
	end

	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule
